// ==== src/mrs_pkg.sv ====
/*
  constants for the receive store and line control block.
  assumes a 32-bit apb master and a 250 mhz pclk.
*/
`default_nettype none
package mrs_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int unsigned LINES = 16;
  localparam int unsigned SILO_DEPTH = 64;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned LINE_W = 4;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned LEVEL_W = 6;
  localparam int unsigned EXT_W = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned SHIFT_TIME_NS = 1000;
  localparam int unsigned SHIFT_CYCLES = (SHIFT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SCR = 8'h00;
  localparam logic [7:0] OFS_NRC = 8'h04;
  localparam logic [7:0] OFS_SSR = 8'h08;
  localparam logic [7:0] OFS_BRK = 8'h0c;
  localparam logic [7:0] OFS_LEN = 8'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned SCR_IE_BIT = 6;
  localparam int unsigned SCR_RXI_BIT = 7;
  localparam int unsigned SCR_MAINT_BIT = 9;
  localparam int unsigned SCR_NXM_BIT = 10;
  localparam int unsigned SCR_OVF_BIT = 14;
  localparam int unsigned SCR_TXI_BIT = 15;
  localparam int unsigned NRC_VALID_BIT = 15;
  localparam int unsigned NRC_LINE_LSB = 8;
  localparam int unsigned SSR_LEVEL_LSB = 0;
  localparam int unsigned SSR_EXT_LSB = 6;
  localparam int unsigned SSR_CNT_LSB = 8;
  localparam int unsigned SSR_MNT_BIT = 15;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [15:0] TEST_PATTERN = 16'haaaa;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ==== src/mrs_tick_div.sv ====
/*
  divider giving a one-cycle enable pulse every COUNT clocks.
  assumes COUNT of at least 2.
*/
`timescale 1ns/100ps
`default_nettype none
module mrs_tick_div #(
  parameter int unsigned COUNT = 250
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  localparam int unsigned W = $clog2(COUNT + 1);
  localparam logic [W-1:0] LAST = W'(COUNT - 1);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == LAST) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // mrs_tick_div
`default_nettype wire

// ==== src/mrs_silo_ctrl.sv ====
/*
  receive character store, alarm, break, loopback and apb registers.
  assumes receivers and transmitters on pclk; serial_in comes from pins.
*/
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
//
// Functional notes
// R1: loaded words fall to lowest free slot
// R2: empty store passes word straight to bottom
// R3: top-to-bottom fall time is bounded, tolerated
// R4: one position moved per microsecond tick
// R5: alarm needs count over level and bottom word
// R6: counter includes words still falling
// R7: bit 15 of read word flags valid data
// R8: alarm level takes any value 0..63
// R9: software reads at most once per microsecond
// R10: drain routine runs at receiver priority
// R11: disabled line delivers no characters
// R12: break bit forces line output low
// R13: tx flag set when last character loaded
// R14: two characters may still be queued then
// R15: software queues two nulls before break
// R16: reset clears store, lines and registers
// R17: scanner restarts from line zero
// R18: maintenance makes bits 7,10,14 writable
// R19: maintenance bit 7 is flop or alarm
// R20: read of bit 7 as one sets flop
// R21: maintenance loops each tx to rx
// R22: each rise of bit 15 loads one pattern
// R23: software stops lines before pattern test
// R24: test word is alternating one-zero pattern
// R25: six-bit count reads zero when full
// R26: level in bits 0-5, bit 6 enables
// R27: refused character sets overflow flag
// R28: reading next character pops bottom word
// R29: empty bottom reads with valid bit zero
module mrs_silo_ctrl #(
  parameter int unsigned DEPTH = mrs_pkg::SILO_DEPTH,
  parameter int unsigned SHIFT_CYC = mrs_pkg::SHIFT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mrs_pkg::LINES-1:0] rx_char_available,
  input wire logic [mrs_pkg::LINES*mrs_pkg::CHAR_W-1:0] rx_char_bus,
  output logic [mrs_pkg::LINES-1:0] rx_take,
  input wire logic [mrs_pkg::LINES-1:0] tx_serial,
  input wire logic [mrs_pkg::LINES-1:0] serial_in,
  input wire logic [mrs_pkg::LINES-1:0] tx_last_loaded,
  input wire logic [mrs_pkg::LINES-1:0] nxm_event,
  input wire logic [mrs_pkg::EXT_W-1:0] ext_addr,
  output logic [mrs_pkg::LINES-1:0] line_serial_out,
  output logic [mrs_pkg::LINES-1:0] line_rx_serial,
  output logic [mrs_pkg::LINES-1:0] line_enable,
  output logic rx_int_req,
  output logic tx_int_req
);
  import mrs_pkg::*;

  localparam int unsigned CNT_W = $clog2(DEPTH) + 1;
  localparam int unsigned TOP = DEPTH - 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] silo_reg [DEPTH];
  logic [DEPTH-1:0] occ_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [DEPTH-2:0] mv;
  logic tick;
  logic ie_reg, maint_reg, rxi_ff_reg, nxm_reg, ovf_reg, txi_reg;
  logic [LEVEL_W-1:0] level_reg;
  logic ssr_mnt_reg, pat_pend_reg;
  logic [LINES-1:0] brk_reg;
  logic [LINE_W-1:0] scan_reg;
  logic [LINES-1:0] sin_meta_reg, sin_sync_reg;
  logic setup, acc, wr_acc, rd_acc;
  logic sel_scr, sel_nrc, sel_ssr, sel_brk, sel_len, sel_any;
  logic alarm, rxi_val, top_free, empty;
  logic scan_avail, push, pop, ovf_event, pat_req;
  logic [WORD_W-1:0] push_word;
  logic [WORD_W-1:0] scr_val, ssr_val, rd_val;
  logic [LINES-1:0] tx_line;

  mrs_tick_div #(.COUNT(SHIFT_CYC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr_acc = acc & pwrite;
  assign rd_acc = acc & ~pwrite;
  assign sel_scr = (paddr == OFS_SCR);
  assign sel_nrc = (paddr == OFS_NRC);
  assign sel_ssr = (paddr == OFS_SSR);
  assign sel_brk = (paddr == OFS_BRK);
  assign sel_len = (paddr == OFS_LEN);
  assign sel_any = sel_scr | sel_nrc | sel_ssr | sel_brk | sel_len;

  // ----------------------------------------------------------------
  // alarm and status words
  // ----------------------------------------------------------------
  assign alarm = (cnt_reg > CNT_W'(level_reg)) & occ_reg[0]; // [R5] [R6] [R8]
  assign rxi_val = maint_reg ? (rxi_ff_reg | alarm) : alarm; // [R19]

  always_comb begin
    scr_val = '0;
    scr_val[SCR_IE_BIT] = ie_reg;
    scr_val[SCR_RXI_BIT] = rxi_val; // [R26]
    scr_val[SCR_MAINT_BIT] = maint_reg;
    scr_val[SCR_NXM_BIT] = nxm_reg;
    scr_val[SCR_OVF_BIT] = ovf_reg;
    scr_val[SCR_TXI_BIT] = txi_reg;
    ssr_val = '0;
    ssr_val[SSR_LEVEL_LSB +: LEVEL_W] = level_reg;
    ssr_val[SSR_EXT_LSB +: EXT_W] = ext_addr;
    ssr_val[SSR_CNT_LSB +: LEVEL_W] = cnt_reg[LEVEL_W-1:0]; // [R25]
    ssr_val[SSR_MNT_BIT] = ssr_mnt_reg;
    rd_val = '0;
    if (sel_scr) begin
      rd_val = scr_val;
    end else if (sel_nrc) begin
      rd_val = occ_reg[0] ? silo_reg[0] : '0; // [R7] [R29]
    end else if (sel_ssr) begin
      rd_val = ssr_val;
    end else if (sel_brk) begin
      rd_val = brk_reg;
    end else if (sel_len) begin
      rd_val = line_enable;
    end
  end

  // ----------------------------------------------------------------
  // apb slave: data latched in setup, ready in access
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= (sel_any && !pwrite) ? {16'h0000, rd_val} : RD_ZERO;
        pslverr <= ~sel_any;
      end else if (acc) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver scanner and store input
  // ----------------------------------------------------------------
  assign top_free = ~occ_reg[TOP];
  assign empty = ~|occ_reg;
  assign scan_avail = rx_char_available[scan_reg] & line_enable[scan_reg] & ~pat_pend_reg; // [R11]
  assign push = (pat_pend_reg | scan_avail) & top_free;
  assign ovf_event = scan_avail & ~top_free; // [R27]
  assign push_word = pat_pend_reg ? TEST_PATTERN : // [R24]
                     {1'b1, 3'b000, scan_reg, rx_char_bus[scan_reg*CHAR_W +: CHAR_W]}; // [R7]
  assign pop = rd_acc & sel_nrc & prdata[NRC_VALID_BIT]; // [R28]
  assign pat_req = wr_acc & sel_ssr & pwdata[SSR_MNT_BIT] & ~ssr_mnt_reg; // [R22]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_reg <= '0; // [R17]
      rx_take <= '0;
    end else begin
      scan_reg <= scan_reg + 1'b1; // [R17]
      rx_take <= '0;
      if (scan_avail && top_free) begin
        rx_take[scan_reg] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // fall-through store
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < DEPTH - 1; i++) begin
      mv[i] = tick & ~occ_reg[i] & occ_reg[i+1]; // [R1] [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      occ_reg <= '0; // [R16]
    end else begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        if (mv[i]) begin
          occ_reg[i] <= 1'b1; // [R3]
          occ_reg[i+1] <= 1'b0;
        end
      end
      if (pop) begin
        occ_reg[0] <= 1'b0;
      end
      if (push && empty) begin
        occ_reg[0] <= 1'b1; // [R2]
      end else if (push) begin
        occ_reg[TOP] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk) begin
    for (int i = 0; i < DEPTH - 1; i++) begin
      if (mv[i]) begin
        silo_reg[i] <= silo_reg[i+1];
      end
    end
    if (push && empty) begin
      silo_reg[0] <= push_word; // [R2]
    end else if (push) begin
      silo_reg[TOP] <= push_word; // [R1]
    end
  end

  assign cnt_next = cnt_reg + CNT_W'(push) - CNT_W'(pop);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next; // [R6]
    end
  end

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_reg <= 1'b0; // [R16]
      maint_reg <= 1'b0;
      level_reg <= '0;
      ssr_mnt_reg <= 1'b0;
      brk_reg <= '0;
      line_enable <= '0;
    end else if (wr_acc) begin
      if (sel_scr) begin
        ie_reg <= pwdata[SCR_IE_BIT];
        maint_reg <= pwdata[SCR_MAINT_BIT];
      end
      if (sel_ssr) begin
        level_reg <= pwdata[SSR_LEVEL_LSB +: LEVEL_W]; // [R8] [R26]
        ssr_mnt_reg <= pwdata[SSR_MNT_BIT];
      end
      if (sel_brk) begin
        brk_reg <= pwdata[LINES-1:0];
      end
      if (sel_len) begin
        line_enable <= pwdata[LINES-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pat_pend_reg <= 1'b0;
    end else if (pat_req) begin
      pat_pend_reg <= 1'b1; // [R22]
    end else if (top_free) begin
      pat_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxi_ff_reg <= 1'b0;
    end else if (wr_acc && sel_scr && maint_reg) begin
      rxi_ff_reg <= pwdata[SCR_RXI_BIT]; // [R18]
    end else if (rd_acc && sel_scr && maint_reg && prdata[SCR_RXI_BIT]) begin
      rxi_ff_reg <= 1'b1; // [R20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
      nxm_reg <= 1'b0;
      txi_reg <= 1'b0;
    end else begin
      if (ovf_event) begin
        ovf_reg <= 1'b1; // [R27]
      end else if (wr_acc && sel_scr && maint_reg) begin
        ovf_reg <= pwdata[SCR_OVF_BIT]; // [R18]
      end else if (pop) begin
        ovf_reg <= 1'b0;
      end
      if (|nxm_event) begin
        nxm_reg <= 1'b1;
      end else if (wr_acc && sel_scr && maint_reg) begin
        nxm_reg <= pwdata[SCR_NXM_BIT]; // [R18]
      end
      if (|tx_last_loaded) begin
        txi_reg <= 1'b1; // [R13] [R14]
      end else if (wr_acc && sel_scr) begin
        txi_reg <= pwdata[SCR_TXI_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // line outputs, break and loopback
  // ----------------------------------------------------------------
  assign tx_line = tx_serial & ~brk_reg; // [R12]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sin_meta_reg <= '1;
      sin_sync_reg <= '1;
      line_serial_out <= '1;
      line_rx_serial <= '1;
      rx_int_req <= 1'b0;
      tx_int_req <= 1'b0;
    end else begin
      sin_meta_reg <= serial_in;
      sin_sync_reg <= sin_meta_reg;
      line_serial_out <= tx_line; // [R12]
      line_rx_serial <= maint_reg ? tx_line : sin_sync_reg; // [R21]
      rx_int_req <= ie_reg & rxi_val; // [R26]
      tx_int_req <= txi_reg;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_empty_fall: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
    (push && empty && !pop) |=> (occ_reg[0] && silo_reg[0] == $past(push_word)))
    else $error("word did not fall through to bottom");
  chk_alarm_cond: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
    (rx_int_req && !$past(maint_reg)) |-> $past(cnt_reg > CNT_W'(level_reg) && occ_reg[0]))
    else $error("receiver request without alarm condition");
  chk_break_low: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
    1'b1 |=> ((line_serial_out & $past(brk_reg)) == '0))
    else $error("break line not held at space");
  chk_line_off: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
    1'b1 |=> ((rx_take & ~$past(line_enable)) == '0))
    else $error("character taken from disabled line");
  chk_empty_read: assert property (@(posedge pclk) disable iff (!presetn) // [R29]
    (setup && !pwrite && sel_nrc && !occ_reg[0]) |=> !prdata[NRC_VALID_BIT])
    else $error("empty read shows valid data");
  chk_pop_count: assert property (@(posedge pclk) disable iff (!presetn) // [R28]
    (pop && !push) |=> (cnt_reg == $past(cnt_reg) - 1'b1 && !occ_reg[0] || $past(mv[0])))
    else $error("read did not remove bottom word");
  chk_no_tick_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
    (!tick && !push && !pop) |=> (occ_reg == $past(occ_reg)))
    else $error("store moved without shift tick");
  chk_pattern_load: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
    (pat_req && !pat_pend_reg) |=> pat_pend_reg ##1 (!pat_pend_reg || !top_free))
    else $error("pattern load not issued once");
  chk_ovf_set: assert property (@(posedge pclk) disable iff (!presetn) // [R27]
    ovf_event |=> ovf_reg)
    else $error("overflow flag not set on refusal");
  chk_loop_back: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
    maint_reg |=> (line_rx_serial == $past(tx_line)))
    else $error("maintenance loopback broken");
  chk_tx_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
    (|tx_last_loaded) |=> txi_reg ##1 tx_int_req)
    else $error("transmit flag not raised on last load");
  chk_maint_lock: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
    (wr_acc && sel_scr && !maint_reg && !ovf_reg && !ovf_event) |=> !ovf_reg)
    else $error("overflow flag written outside maintenance");
endmodule // mrs_silo_ctrl
`default_nettype wire

// ==== tb/mrs_line_model.sv ====
/*
  behavioural model of the sixteen line receivers feeding the store.
  assumes the bench loads characters through put and put_char.
*/
`timescale 1ns/100ps
`default_nettype none
module mrs_line_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [15:0] rx_take,
  input wire logic [15:0] put,
  input wire logic [127:0] put_char,
  output logic [15:0] rx_char_available,
  output logic [127:0] rx_char_bus
);
  // ----------------------------------------------------------------
  // receiver holding stages
  // ----------------------------------------------------------------
  logic [127:0] hold_reg;
  logic [3:0] cnt_reg [16];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_char_available <= '0;
      hold_reg <= '0;
      for (int i = 0; i < 16; i++) cnt_reg[i] <= '0;
    end else begin
      for (int i = 0; i < 16; i++) begin
        if (put[i]) begin
          rx_char_available[i] <= 1'b1;
          hold_reg[i*8+:8] <= put_char[i*8+:8];
          cnt_reg[i] <= '0;
        end else if (rx_take[i] && !slow) begin
          rx_char_available[i] <= 1'b0;
        end else if (rx_take[i]) begin
          cnt_reg[i] <= 4'd8;
        end else if (cnt_reg[i] != 0) begin
          cnt_reg[i] <= cnt_reg[i] - 4'd1;
          if (cnt_reg[i] == 4'd1) rx_char_available[i] <= 1'b0;
        end
      end
    end
  end
  // released holding stage shows garbage, not the old character
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      rx_char_bus[i*8+:8] = rx_char_available[i] ? hold_reg[i*8+:8] : ~hold_reg[i*8+:8];
    end
  end
endmodule // mrs_line_model
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  self-checking bench: apb master, line model, random and corner cases.
  assumes the store block with a shortened shift tick.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mrs_pkg::*;
  localparam int SC = 4;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxi, txi, slow, ps;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] avail, take, txs, sin, txl, nxm, lso, lrx, len, put, brk;
  logic [127:0] cbus, pch;
  logic [1:0] ext;
  logic [31:0] q[$];
  int err_total, checked, seed, cyc, i, n;
  logic [3:0] ln;
  logic [7:0] ch;

  mrs_silo_ctrl #(.DEPTH(64), .SHIFT_CYC(SC)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_char_available(avail),
    .rx_char_bus(cbus), .rx_take(take), .tx_serial(txs), .serial_in(sin),
    .tx_last_loaded(txl), .nxm_event(nxm), .ext_addr(ext), .line_serial_out(lso),
    .line_rx_serial(lrx), .line_enable(len), .rx_int_req(rxi), .tx_int_req(txi));
  mrs_line_model lines (.pclk(pclk), .presetn(presetn), .slow(slow), .rx_take(take),
    .put(put), .put_char(pch), .rx_char_available(avail), .rx_char_bus(cbus));

  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nrc_w(logic [3:0] l, logic [7:0] c);
    return {16'h0000, 1'b1, 3'b000, l, c};
  endfunction
  function automatic logic [31:0] ssr_w(logic b, logic [5:0] c, logic [5:0] lv);
    return {16'h0000, b, 1'b0, c, ext, lv};
  endfunction
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge pclk);
    end
    rd = prdata;
    ps = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0000_0000);
    chk(nm, rd, e);
  endtask
  task automatic put_ch(input logic [3:0] l, input logic [7:0] c);
    @(posedge pclk);
    put[l] <= 1;
    pch[l*8+:8] <= c;
    @(posedge pclk);
    put <= '0;
  endtask
  task automatic wt(input logic [3:0] l, input logic [7:0] c);
    int k;
    k = 0;
    while (take[l] !== 1'b1 && k < 100) begin
      k++;
      @(posedge pclk);
    end
    chk("take", {31'h0, take[l]}, 32'h0000_0001);
    q.push_back(nrc_w(l, c));
    @(posedge pclk);
  endtask
  task automatic pat(input logic [5:0] lv);
    apb(1, OFS_SSR, {26'h0, lv});
    apb(1, OFS_SSR, {16'h0, 1'b1, 9'h0, lv});
    q.push_back(32'h0000_aaaa);
    repeat (6) @(posedge pclk);
  endtask
  task automatic drain(input string nm);
    repeat (70 * SC) @(posedge pclk);
    while (q.size() > 0) begin
      repeat (2 * SC) @(posedge pclk);
      rdc(nm, OFS_NRC, q.pop_front());
    end
    repeat (2 * SC) @(posedge pclk);
    rdc("nrc_empty", OFS_NRC, 32'h0000_0000);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 1318;
    err_total = 0;
    checked = 0;
    cyc = 0;
    {psel, penable, pwrite, slow} = '0;
    {paddr, pwdata, put, pch, txl, nxm} = '0;
    txs = '1;
    sin = '1;
    ext = 2'($random(seed));
    presetn = 0;
    repeat (20) @(posedge pclk);
    chk("lso_rst", {16'h0, lso}, 32'h0000_ffff);
    presetn <= 1;
    rdc("scr_rst", OFS_SCR, 32'h0000_0000);
    rdc("ssr_rst", OFS_SSR, ssr_w(0, 0, 0));
    rdc("nrc_rst", OFS_NRC, 32'h0000_0000);
    rdc("unmapped", 8'h20, 32'h0000_0000);
    chk("slverr", {31'h0, ps}, 32'h0000_0001);
    // pattern words, a repeated set without a clear loads nothing
    pat(0);
    pat(0);
    apb(1, OFS_SSR, 32'h0000_8000);
    repeat (10) @(posedge pclk);
    rdc("ssr_two", OFS_SSR, ssr_w(1, 2, 0));
    drain("nrc_pat");
    // disabled line keeps its character
    apb(1, OFS_LEN, 32'h0000_fff7);
    put_ch(3, 8'h5a);
    n = 0;
    repeat (40) begin
      @(posedge pclk);
      n += take[3];
    end
    chk("no_take", n, 0);
    apb(1, OFS_LEN, 32'h0000_ffff);
    wt(3, 8'h5a);
    apb(1, OFS_SCR, 32'h0000_0040);
    for (i = 0; i < 8; i++) begin
      ln = 4'($random(seed));
      ch = 8'($random(seed));
      slow <= 1'($random(seed));
      put_ch(ln, ch);
      wt(ln, ch);
    end
    rdc("ssr_cnt", OFS_SSR, ssr_w(1, 6'(q.size()), 0));
    chk("rxi_on", {31'h0, rxi}, 32'h0000_0001);
    drain("nrc_rx");
    chk("rxi_off", {31'h0, rxi}, 32'h0000_0000);
    // fill to the top with level 63
    for (i = 0; i < 63; i++) pat(63);
    chk("rxi_63", {31'h0, rxi}, 32'h0000_0000);
    pat(63);
    chk("rxi_64", {31'h0, rxi}, 32'h0000_0001);
    rdc("ssr_full", OFS_SSR, ssr_w(1, 0, 63));
    put_ch(5, 8'hc3);
    repeat (40) @(posedge pclk);
    rdc("scr_ovf", OFS_SCR, 32'h0000_40c0);
    q.push_back(nrc_w(5, 8'hc3));
    drain("nrc_full");
    // break and loopback
    for (i = 0; i < 4; i++) begin
      brk = 16'($random(seed));
      apb(1, OFS_SCR, 32'h0000_0000);
      apb(1, OFS_BRK, {16'h0, brk});
      txs <= 16'($random(seed));
      sin <= 16'($random(seed));
      repeat (5) @(posedge pclk);
      chk("lso", {16'h0, lso}, {16'h0, txs & ~brk});
      chk("lrx", {16'h0, lrx}, {16'h0, sin});
      apb(1, OFS_SCR, 32'h0000_0200);
      repeat (3) @(posedge pclk);
      chk("loop", {16'h0, lrx}, {16'h0, txs & ~brk});
    end
    apb(1, OFS_SCR, 32'h0000_0000);
    apb(1, OFS_BRK, 32'h0000_0000);
    // flags and maintenance writes
    @(posedge pclk);
    nxm[2] <= 1;
    txl[1] <= 1;
    @(posedge pclk);
    {nxm, txl} <= '0;
    repeat (3) @(posedge pclk);
    chk("txi", {31'h0, txi}, 32'h0000_0001);
    rdc("scr_ev", OFS_SCR, 32'h0000_8400);
    apb(1, OFS_SCR, 32'h0000_44c0);
    rdc("scr_ro", OFS_SCR, 32'h0000_0440);
    apb(1, OFS_SCR, 32'h0000_0200);
    apb(1, OFS_SCR, 32'h0000_46c0);
    rdc("scr_mnt", OFS_SCR, 32'h0000_46c0);
    repeat (2) @(posedge pclk);
    chk("rxi_mnt", {31'h0, rxi}, 32'h0000_0001);
    apb(1, OFS_SCR, 32'h0000_0200);
    rdc("scr_clr", OFS_SCR, 32'h0000_0200);
    // reset in mid-run
    pat(0);
    apb(1, OFS_BRK, 32'h0000_ffff);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("lso_mid", {16'h0, lso}, 32'h0000_ffff);
    presetn <= 1;
    q.delete();
    rdc("scr_mid", OFS_SCR, 32'h0000_0000);
    rdc("ssr_mid", OFS_SSR, ssr_w(0, 0, 0));
    rdc("nrc_mid", OFS_NRC, 32'h0000_0000);
    rdc("len_mid", OFS_LEN, 32'h0000_0000);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
